// file: gauge_ctrl_pkg.sv
package gauge_ctrl_pkg;
  // =========================================
  // command codes and subcommands
  localparam logic [7:0] CMD_CONTROL = 8'h00;
  localparam logic [7:0] CMD_OPCFG = 8'h3A;
  localparam logic [7:0] CMD_RAM_BASE = 8'h40;
  localparam logic [7:0] CMD_FLASH = 8'h60;
  localparam logic [7:0] CMD_PROFILE_STATUS = 8'h6A;
  localparam logic [15:0] SUB_STATUS = 16'h0000;
  localparam logic [15:0] SUB_RESET_DATA = 16'h0005;
  localparam logic [15:0] SUB_SET_HIBERNATE = 16'h0011;
  localparam logic [15:0] SUB_CLR_HIBERNATE = 16'h0012;
  localparam logic [15:0] SUB_RESET = 16'h0041;
  // =========================================
  // field positions
  localparam int OPCFG_RANGE_BIT = 0;
  localparam int OPCFG_SEL_LOW_BIT = 1;
  localparam int OPCFG_SEL_HIGH_BIT = 2;
  localparam int STAT_LAST_PROFILE_BIT = 0;
  localparam int STAT_UNSUPPORTED_BIT = 1;
  localparam int STAT_HIB_REQ_BIT = 0;
  localparam logic [2:0] OPCFG_RESET = 3'h0;
  localparam logic [7:0] PROFILE_STATUS_RESET = 8'h00;
  localparam int RAM_WORDS = 8;
  // =========================================
  // thresholds and timing
  localparam logic [15:0] WAKE_TH_1_0_UV = 16'd1000;
  localparam logic [15:0] WAKE_TH_2_2_UV = 16'd2200;
  localparam logic [15:0] WAKE_TH_4_6_UV = 16'd4600;
  localparam logic [15:0] WAKE_TH_9_8_UV = 16'd9800;
  localparam logic signed [7:0] CAL_TEMP_LOW_C = 8'sd5;
  localparam logic signed [7:0] CAL_TEMP_HIGH_C = 8'sd45;
  localparam logic [15:0] CAL_CURRENT_MA = 16'd100;
  localparam logic [15:0] CAL_VOLT_MOVE_MV = 16'd256;
  localparam logic [7:0] CAL_TEMP_MOVE_C = 8'd8;
  localparam logic [15:0] CAL_ABORT_DROP_MV = 16'd32;
  localparam longint CLK_HZ = 40000000;
  localparam longint CAL_TEMP_HOLD_S = 60;
  localparam longint CAL_TEMP_HOLD_CYC = CAL_TEMP_HOLD_S * CLK_HZ;
  // impedance match window is z*i/2^ZTOL_SHIFT
  localparam int ZTOL_SHIFT = 3;
  localparam logic [15:0] DEFAULT_Z_MOHM = 16'd150;
  // =========================================
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_req_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } cmd_rsp_t;
  typedef enum logic [1:0] {ST_INIT_OCV, ST_SELECT, ST_NORMAL, ST_HIBERNATE} pwr_state_t;

  function automatic logic [15:0] wakeThreshold(input logic [1:0] sel, input logic rng);
    logic [15:0] th;
    th = 16'h0000;
    unique case ({sel, rng})
      3'b010: th = WAKE_TH_1_0_UV;
      3'b011, 3'b100: th = WAKE_TH_2_2_UV;
      3'b101, 3'b110: th = WAKE_TH_4_6_UV;
      3'b111: th = WAKE_TH_9_8_UV;
      default: th = 16'h0000;
    endcase
    return th;
  endfunction

  function automatic logic [15:0] absS16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction
endpackage

// file: wake_comparator.sv
`timescale 1ns/1ps
module wake_comparator (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // configuration
  input wire logic armed,
  input wire logic [1:0] senseSel,
  input wire logic wakeRangeSelect,
  // sense voltage in microvolts, signed
  input wire logic signed [15:0] senseUv,
  // internal interrupt
  output logic wakeEvent
);
  import gauge_ctrl_pkg::*;

  logic [15:0] threshold;
  logic crossed;

  assign threshold = wakeThreshold(senseSel, wakeRangeSelect);
  // symmetric in sign: magnitude compare covers charge and discharge
  assign crossed = (absS16(senseUv) >= threshold);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wakeEvent <= 1'b0;
    end else begin
      wakeEvent <= armed && (senseSel != 2'b00) && crossed;
    end
  end
endmodule

// file: gauge_power_calib_profile_ctrl.sv
`timescale 1ns/1ps
module gauge_power_calib_profile_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // host command port
  input wire gauge_ctrl_pkg::cmd_req_t cmdReq,
  input wire logic addrMatch,
  output gauge_ctrl_pkg::cmd_rsp_t cmdRsp,
  // measurements
  input wire logic ocvValid,
  input wire logic [15:0] ocvMv,
  input wire logic [15:0] cellMv,
  input wire logic signed [15:0] avgCurrentMa,
  input wire logic signed [7:0] tempC,
  input wire logic signed [15:0] senseRawUv,
  input wire logic signed [15:0] senseOffsetUv,
  input wire logic sampleTick,
  // limits from data flash
  input wire logic [15:0] hibCurrentMa,
  input wire logic [15:0] hibVoltageMv,
  input wire logic [15:0] flashOkMv,
  // sleep and calibration handshake
  input wire logic sleepActive,
  input wire logic sleepEntry,
  input wire logic calDone,
  // profile upkeep and soft error
  input wire logic zUpdate,
  input wire logic [15:0] zUpdateMohm,
  input wire logic ramUpset,
  // outputs
  output logic batteryGoodOutput,
  output logic hibernating,
  output logic wakeInterrupt,
  output logic flashWrite,
  output logic [15:0] flashData,
  output logic flashRefused,
  output logic calStart,
  output logic calBusy,
  output logic calAbort,
  output logic signed [15:0] senseCorrectedUv,
  output logic signed [15:0] rateMa,
  output logic signed [31:0] capacityAcc,
  output logic [1:0] activeProfile
);
  import gauge_ctrl_pkg::*;

  parameter longint TEMP_HOLD_CYC = CAL_TEMP_HOLD_CYC;

  // =========================================
  // reset release
  logic [1:0] rstPipe_ff;
  logic rstN;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe_ff <= 2'b00;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstN = rstPipe_ff[1];

  // =========================================
  // command decode
  logic ctrlWr, ramWr, flashWr, opcfgWr;
  assign ctrlWr = cmdReq.valid && cmdReq.write && (cmdReq.code == CMD_CONTROL);
  assign opcfgWr = cmdReq.valid && cmdReq.write && (cmdReq.code == CMD_OPCFG);
  assign flashWr = cmdReq.valid && cmdReq.write && (cmdReq.code == CMD_FLASH);
  assign ramWr = cmdReq.valid && cmdReq.write && (cmdReq.code[7:3] == CMD_RAM_BASE[7:3]);

  logic [2:0] opcfg_ff;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      opcfg_ff <= OPCFG_RESET;
    end else if (opcfgWr) begin
      opcfg_ff <= cmdReq.data[2:0];
    end
  end

  // =========================================
  // power state machine
  pwr_state_t state_ff, nxt_state;
  logic hibReq_ff, ocvTaken_ff;
  logic [15:0] ocvHeld_ff;
  logic hibByCurrent, hibByVoltage;
  assign hibByCurrent = hibReq_ff && ocvTaken_ff && (absS16(avgCurrentMa) < hibCurrentMa);
  assign hibByVoltage = ocvTaken_ff && (cellMv < hibVoltageMv);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_INIT_OCV: if (ocvValid) nxt_state = ST_SELECT;
      ST_SELECT: nxt_state = ST_NORMAL;
      ST_NORMAL: if (hibByCurrent || hibByVoltage) nxt_state = ST_HIBERNATE;
      ST_HIBERNATE: if (addrMatch) nxt_state = ST_INIT_OCV;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_ff <= ST_INIT_OCV;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // request set by host, cleared by host or on leaving hibernate
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      hibReq_ff <= 1'b0;
    end else if (state_ff == ST_HIBERNATE && addrMatch) begin
      hibReq_ff <= 1'b0;
    end else if (ctrlWr && cmdReq.data == SUB_SET_HIBERNATE) begin
      hibReq_ff <= 1'b1;
    end else if (ctrlWr && cmdReq.data == SUB_CLR_HIBERNATE) begin
      hibReq_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ocvTaken_ff <= 1'b0;
      ocvHeld_ff <= 16'h0000;
    end else if (state_ff == ST_INIT_OCV && ocvValid) begin
      ocvTaken_ff <= 1'b1;
      ocvHeld_ff <= ocvMv;
    end
  end

  // charger held off until an OCV is in after reset or after wake, and during hibernate
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      batteryGoodOutput <= 1'b0;
      hibernating <= 1'b0;
    end else begin
      batteryGoodOutput <= (nxt_state == ST_SELECT) || (nxt_state == ST_NORMAL);
      hibernating <= (nxt_state == ST_HIBERNATE);
    end
  end

  // =========================================
  // wake comparator
  wake_comparator u_wake (
    .clk(core_clk),
    .rstN(rstN),
    .armed(sleepActive || state_ff == ST_HIBERNATE),
    .senseSel({opcfg_ff[OPCFG_SEL_HIGH_BIT], opcfg_ff[OPCFG_SEL_LOW_BIT]}),
    .wakeRangeSelect(opcfg_ff[OPCFG_RANGE_BIT]),
    .senseUv(senseRawUv),
    .wakeEvent(wakeInterrupt)
  );

  // =========================================
  // scratch RAM, checksum and software reset
  logic [7:0] ram_ff [RAM_WORDS];
  logic [7:0] ramSum_ff, partialCnt_ff, fullCnt_ff;
  logic [7:0] liveSum;
  logic resetCmd, sumBad;
  always_comb begin
    liveSum = 8'h00;
    for (int i = 0; i < RAM_WORDS; i++) begin
      liveSum = 8'(liveSum + ram_ff[i]);
    end
  end
  assign resetCmd = ctrlWr && (cmdReq.data == SUB_RESET);
  assign sumBad = (liveSum != ramSum_ff);

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        ram_ff[i] <= 8'h00;
      end
      ramSum_ff <= 8'h00;
    end else if (resetCmd && sumBad) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        ram_ff[i] <= 8'h00;
      end
      ramSum_ff <= 8'h00;
    end else if (ramWr) begin
      ram_ff[cmdReq.code[2:0]] <= cmdReq.data[7:0];
      ramSum_ff <= 8'(liveSum - ram_ff[cmdReq.code[2:0]] + cmdReq.data[7:0]);
    end else if (ramUpset) begin
      ram_ff[0] <= ~ram_ff[0];
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      partialCnt_ff <= 8'h00;
      fullCnt_ff <= 8'h00;
    end else if (resetCmd) begin
      if (sumBad) begin
        fullCnt_ff <= 8'(fullCnt_ff + 8'h01);
      end else begin
        partialCnt_ff <= 8'(partialCnt_ff + 8'h01);
      end
    end
  end

  // =========================================
  // flash write gate
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      flashWrite <= 1'b0;
      flashRefused <= 1'b0;
      flashData <= 16'h0000;
    end else begin
      flashWrite <= flashWr && (cellMv >= flashOkMv);
      flashRefused <= flashWr && (cellMv < flashOkMv);
      if (flashWr && cellMv >= flashOkMv) begin
        flashData <= cmdReq.data;
      end
    end
  end

  // =========================================
  // offset calibration
  logic [15:0] lastCalMv_ff, calStartMv_ff;
  logic signed [7:0] lastCalTemp_ff;
  logic signed [15:0] offset_ff;
  logic [31:0] tempHold_ff;
  logic tempMoved, voltMoved, tempWarm, singleCal, sleepCal, dropped;
  assign tempMoved = absS16(16'(tempC) - 16'(lastCalTemp_ff)) > 16'(CAL_TEMP_MOVE_C);
  assign voltMoved = absDiff(cellMv, lastCalMv_ff) >= CAL_VOLT_MOVE_MV;
  assign tempWarm = (tempC > CAL_TEMP_LOW_C) && (tempC < CAL_TEMP_HIGH_C);
  assign sleepCal = sleepEntry && tempWarm;
  assign singleCal = (absS16(avgCurrentMa) <= CAL_CURRENT_MA)
                     && (voltMoved || tempHold_ff >= 32'(TEMP_HOLD_CYC));
  assign dropped = (calStartMv_ff > cellMv) && (16'(calStartMv_ff - cellMv) > CAL_ABORT_DROP_MV);

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      tempHold_ff <= 32'h0000_0000;
    end else if (!tempMoved || calBusy) begin
      tempHold_ff <= 32'h0000_0000;
    end else if (tempHold_ff < 32'(TEMP_HOLD_CYC)) begin
      tempHold_ff <= tempHold_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      calBusy <= 1'b0;
      calStart <= 1'b0;
      calAbort <= 1'b0;
      calStartMv_ff <= 16'h0000;
      lastCalMv_ff <= 16'h0000;
      lastCalTemp_ff <= 8'sh00;
      offset_ff <= 16'sh0000;
    end else begin
      calStart <= 1'b0;
      calAbort <= 1'b0;
      if (calBusy) begin
        if (dropped) begin
          calBusy <= 1'b0;
          calAbort <= 1'b1;
        end else if (calDone) begin
          calBusy <= 1'b0;
          offset_ff <= senseOffsetUv;
          lastCalMv_ff <= cellMv;
          lastCalTemp_ff <= tempC;
        end
      end else if (sleepCal || singleCal) begin
        calBusy <= 1'b1;
        calStart <= 1'b1;
        calStartMv_ff <= cellMv;
      end
    end
  end

  // accumulation keeps the last rate while calibration blocks measuring
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      rateMa <= 16'sh0000;
      capacityAcc <= 32'sh0000_0000;
      senseCorrectedUv <= 16'sh0000;
    end else begin
      if (!calBusy) begin
        rateMa <= avgCurrentMa;
        senseCorrectedUv <= 16'(senseRawUv - offset_ff);
      end
      if (sampleTick) begin
        capacityAcc <= capacityAcc + 32'(rateMa);
      end
    end
  end

  // =========================================
  // profile selection
  logic [15:0] dynZ_ff [2];
  logic [1:0] dynUsed_ff;
  logic lastProfile_ff, unsupported_ff;
  logic signed [32:0] dvUv;
  logic [15:0] iMag;
  logic matchA, matchB;

  function automatic logic zMatch(input logic [15:0] z, input logic signed [32:0] dv,
                                  input logic [15:0] im);
    logic signed [32:0] zi;
    logic signed [32:0] diff;
    zi = 33'(z * im);
    diff = (dv > zi) ? 33'(dv - zi) : 33'(zi - dv);
    return (im != 16'h0000) && (diff <= (zi >>> ZTOL_SHIFT));
  endfunction

  // impedance test without division: (ocv - v)*1000 against z*i
  assign dvUv = 33'((33'(ocvHeld_ff) - 33'(cellMv)) * 33'sd1000);
  assign iMag = absS16(avgCurrentMa);
  assign matchA = dynUsed_ff[0] && zMatch(dynZ_ff[0], dvUv, iMag);
  assign matchB = dynUsed_ff[1] && zMatch(dynZ_ff[1], dvUv, iMag);

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      dynZ_ff[0] <= 16'h0000;
      dynZ_ff[1] <= 16'h0000;
      dynUsed_ff <= 2'b00;
      lastProfile_ff <= 1'b0;
      unsupported_ff <= 1'b0;
      activeProfile <= 2'b00;
    end else if (state_ff == ST_SELECT) begin
      if (dynUsed_ff == 2'b00) begin
        dynZ_ff[0] <= DEFAULT_Z_MOHM;
        dynZ_ff[1] <= DEFAULT_Z_MOHM;
        dynUsed_ff <= 2'b11;
        lastProfile_ff <= 1'b0;
        activeProfile <= 2'b00;
      end else if (matchA) begin
        lastProfile_ff <= 1'b0;
        activeProfile <= 2'b00;
      end else if (matchB) begin
        lastProfile_ff <= 1'b1;
        activeProfile <= 2'b01;
      end else begin
        dynZ_ff[!lastProfile_ff] <= DEFAULT_Z_MOHM;
        lastProfile_ff <= !lastProfile_ff;
        activeProfile <= {1'b0, !lastProfile_ff};
      end
    end else if (zUpdate && state_ff == ST_NORMAL) begin
      dynZ_ff[lastProfile_ff] <= zUpdateMohm;
    end
  end

  // =========================================
  // read answers
  logic [7:0] profStatus;
  logic [15:0] ctrlAnswer_ff;
  always_comb begin
    profStatus = PROFILE_STATUS_RESET;
    profStatus[STAT_UNSUPPORTED_BIT] = unsupported_ff;
    profStatus[STAT_LAST_PROFILE_BIT] = lastProfile_ff;
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ctrlAnswer_ff <= SUB_STATUS;
    end else if (ctrlWr) begin
      ctrlAnswer_ff <= cmdReq.data;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      cmdRsp <= '0;
    end else begin
      cmdRsp.valid <= cmdReq.valid && !cmdReq.write;
      cmdRsp.data <= 16'h0000;
      if (cmdReq.valid && !cmdReq.write) begin
        unique case (cmdReq.code)
          CMD_CONTROL: cmdRsp.data <= (ctrlAnswer_ff == SUB_RESET_DATA)
              ? {fullCnt_ff, partialCnt_ff} : 16'({hibReq_ff});
          CMD_OPCFG: cmdRsp.data <= 16'(opcfg_ff);
          CMD_PROFILE_STATUS: cmdRsp.data <= 16'(profStatus);
          default: cmdRsp.data <= (cmdReq.code[7:3] == CMD_RAM_BASE[7:3])
              ? 16'(ram_ff[cmdReq.code[2:0]]) : 16'h0000;
        endcase
      end
    end
  end

  // =========================================
  // checks
  property p_hibEntry;
    @(posedge core_clk) disable iff (!rstN)
    state_ff == ST_NORMAL && hibByCurrent |=> state_ff == ST_HIBERNATE;
  endproperty
  a_hibEntry: assert property (p_hibEntry) else $error("hibernate entry missed");

  property p_hibNeedsOcv;
    @(posedge core_clk) disable iff (!rstN)
    $rose(hibernating) |-> $past(ocvTaken_ff, 2);
  endproperty
  a_hibNeedsOcv: assert property (p_hibNeedsOcv) else $error("hibernate without OCV");

  property p_hibStays;
    @(posedge core_clk) disable iff (!rstN)
    state_ff == ST_HIBERNATE && !addrMatch |=> state_ff == ST_HIBERNATE;
  endproperty
  a_hibStays: assert property (p_hibStays) else $error("hibernate left unaddressed");

  property p_bgOff;
    @(posedge core_clk) disable iff (!rstN)
    state_ff == ST_HIBERNATE |-> !batteryGoodOutput;
  endproperty
  a_bgOff: assert property (p_bgOff) else $error("battery good on in hibernate");

  property p_wakeInit;
    @(posedge core_clk) disable iff (!rstN)
    state_ff == ST_HIBERNATE && addrMatch |=> state_ff == ST_INIT_OCV && !hibReq_ff;
  endproperty
  a_wakeInit: assert property (p_wakeInit) else $error("wake did not reinit");

  property p_resetCount;
    @(posedge core_clk) disable iff (!rstN)
    resetCmd |=> (partialCnt_ff != $past(partialCnt_ff)) != (fullCnt_ff != $past(fullCnt_ff));
  endproperty
  a_resetCount: assert property (p_resetCount) else $error("reset not counted once");

  property p_flashGate;
    @(posedge core_clk) disable iff (!rstN)
    flashWr && cellMv < flashOkMv |=> !flashWrite && flashRefused;
  endproperty
  a_flashGate: assert property (p_flashGate) else $error("low-voltage flash write");

  property p_calAbort;
    @(posedge core_clk) disable iff (!rstN)
    calBusy && dropped |=> calAbort && !calBusy ##1 !calAbort;
  endproperty
  a_calAbort: assert property (p_calAbort) else $error("calibration not aborted");

  property p_coldSleep;
    @(posedge core_clk) disable iff (!rstN)
    !calBusy && sleepEntry && !tempWarm && !singleCal |=> !calStart;
  endproperty
  a_coldSleep: assert property (p_coldSleep) else $error("calibration out of range");

  c_hib: cover property (@(posedge core_clk) disable iff (!rstN)
    state_ff == ST_HIBERNATE ##[1:20] state_ff == ST_INIT_OCV);
  c_abort: cover property (@(posedge core_clk) disable iff (!rstN) calAbort);
  c_fullReset: cover property (@(posedge core_clk) disable iff (!rstN) resetCmd && sumBad);
endmodule

// file: host_cmd_model.sv
`timescale 1ns/1ps
module host_cmd_model (
  // clock
  input wire logic core_clk,
  // command side
  output gauge_ctrl_pkg::cmd_req_t cmdReq,
  output logic addrMatch
);
  import gauge_ctrl_pkg::*;
  initial begin
    cmdReq = '0;
    addrMatch = 1'b0;
  end
  // ====
  // one request cycle, then idle
  task send(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    cmdReq <= '{valid: 1'b1, write: w, code: c, data: d};
    @(posedge core_clk);
    cmdReq <= '0;
  endtask
  // addressed transaction is the only way out of hibernate
  task wake();
    @(posedge core_clk);
    addrMatch <= 1'b1;
    @(posedge core_clk);
    addrMatch <= 1'b0;
  endtask
endmodule

// file: test_gauge_power_calib_profile_ctrl.sv
`timescale 1ns/1ps
module test_gauge_power_calib_profile_ctrl;
  import gauge_ctrl_pkg::*;
  // ====
  // signals
  localparam int TH [8] = '{0, 0, 1000, 2200, 2200, 4600, 4600, 9800};
  logic core_clk, nrst, sleepActive, addrMatch, bg, hib, wakeInt, fw, fr, cs, cb, ca;
  logic [5:0] pul;
  logic [15:0] cellMv, flashData, d, th, ocv, zMohm;
  logic signed [15:0] avgCurrentMa, senseRawUv, senseOffsetUv, corr, rate;
  logic signed [31:0] capAcc;
  logic [1:0] actProf;
  logic signed [7:0] tempC;
  cmd_req_t cmdReq;
  cmd_rsp_t cmdRsp;
  logic [15:0] expq [$];
  int errTotal = 0, totalChecks = 0, seed = 89, k, s0, a0, nS = 0, nA = 0, nW = 0, nR = 0;
  host_cmd_model host_cmd_model_inst (.core_clk(core_clk), .cmdReq(cmdReq), .addrMatch(addrMatch));
  gauge_power_calib_profile_ctrl #(.TEMP_HOLD_CYC(50)) gauge_power_calib_profile_ctrl_inst (
    .core_clk(core_clk), .nrst(nrst), .cmdReq(cmdReq), .addrMatch(addrMatch), .cmdRsp(cmdRsp),
    .ocvValid(pul[0]), .ocvMv(ocv), .cellMv(cellMv), .avgCurrentMa(avgCurrentMa),
    .tempC(tempC), .senseRawUv(senseRawUv), .senseOffsetUv(senseOffsetUv), .sampleTick(pul[4]),
    .hibCurrentMa(16'd50), .hibVoltageMv(16'd3000), .flashOkMv(16'd3500),
    .sleepActive(sleepActive), .sleepEntry(pul[1]), .calDone(pul[3]), .zUpdate(pul[5]),
    .zUpdateMohm(zMohm), .ramUpset(pul[2]), .batteryGoodOutput(bg), .hibernating(hib),
    .wakeInterrupt(wakeInt), .flashWrite(fw), .flashData(flashData), .flashRefused(fr),
    .calStart(cs), .calBusy(cb), .calAbort(ca), .senseCorrectedUv(corr), .rateMa(rate),
    .capacityAcc(capAcc), .activeProfile(actProf));
  // ====
  // helpers
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task pulse(input int i);
    @(posedge core_clk);
    pul[i] <= 1'b1;
    @(posedge core_clk);
    pul[i] <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e);
    expq.push_back(e);
    host_cmd_model_inst.send(1'b0, c, 16'h0000);
  endtask
  task conclude();
    if (expq.size() != 0) errTotal++;
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ====
  // monitors
  always @(posedge core_clk) begin
    if (cmdRsp.valid === 1'b1) begin
      if (expq.size() != 0) chk("cmdRsp.data", expq.pop_front(), cmdRsp.data);
      else chk("cmdRsp.valid", 0, 1);
    end
    if (cs === 1'b1) nS++;
    if (ca === 1'b1) nA++;
    if (fw === 1'b1) nW++;
    if (fr === 1'b1) nR++;
  end
  initial begin
    w(20000);
    errTotal++;
    conclude();
  end
  // ====
  // scenarios
  initial begin
    nrst = 1'b0;
    sleepActive = 1'b0;
    pul = '0;
    cellMv = 16'd3800;
    avgCurrentMa = 16'sd500;
    tempC = 8'sd25;
    senseRawUv = '0;
    senseOffsetUv = '0;
    ocv = 16'd3900;
    zMohm = 16'd150;
    w(3);
    nrst <= 1'b1;
    w(4);
    rd(CMD_PROFILE_STATUS, 16'h0000);
    chk("batteryGood", 0, bg);
    pulse(0);
    w(3);
    chk("batteryGood", 1, bg);
    chk("activeProfile", 0, actProf);
    host_cmd_model_inst.send(1'b1, CMD_CONTROL, SUB_SET_HIBERNATE);
    w(3);
    chk("hibernating", 0, hib);
    avgCurrentMa <= -16'sd20;
    w(3);
    chk("hibernating", 1, hib);
    chk("batteryGood", 0, bg);
    avgCurrentMa <= 16'sd500;
    w(5);
    chk("hibernating", 1, hib);
    host_cmd_model_inst.wake();
    w(2);
    chk("hibernating", 0, hib);
    chk("batteryGood", 0, bg);
    rd(CMD_CONTROL, 16'h0000);
    pulse(0);
    w(3);
    chk("batteryGood", 1, bg);
    chk("activeProfile", 1, actProf);
    rd(CMD_PROFILE_STATUS, 16'h0001);
    // retune the active dynamic profile so the next insertion matches it
    zMohm <= 16'd250;
    pulse(5);
    cellMv <= 16'd2900;
    w(3);
    chk("hibernating", 1, hib);
    cellMv <= 16'd3800;
    host_cmd_model_inst.wake();
    ocv <= 16'd3925;
    pulse(0);
    sleepActive <= 1'b1;
    for (k = 0; k < 8; k++) begin
      host_cmd_model_inst.send(1'b1, CMD_OPCFG, 16'(k));
      th = 16'(TH[k]);
      senseRawUv <= ($random(seed) & 1) ? 16'(-th) : th;
      w(3);
      chk("wakeInterrupt", th != 0, wakeInt);
      senseRawUv <= (th != 0) ? 16'(th - 1) : 16'h3E80;
      w(3);
      chk("wakeInterrupt", 0, wakeInt);
    end
    chk("activeProfile", 1, actProf);
    sleepActive <= 1'b0;
    cellMv <= 16'd3400;
    d = 16'($random(seed));
    host_cmd_model_inst.send(1'b1, CMD_FLASH, d);
    w(3);
    chk("flashRefused", 1, nR);
    chk("flashWrite", 0, nW);
    cellMv <= 16'd3500;
    host_cmd_model_inst.send(1'b1, CMD_FLASH, d);
    w(3);
    chk("flashWrite", 1, nW);
    chk("flashData", d, flashData);
    s0 = nS;
    a0 = nA;
    tempC <= 8'sd5;
    pulse(1);
    w(3);
    chk("calStart", s0, nS);
    tempC <= 8'sd25;
    pulse(1);
    w(3);
    chk("calStart", s0 + 1, nS);
    cellMv <= 16'd3468;
    avgCurrentMa <= 16'sd700;
    pulse(4);
    w(2);
    chk("rateMa", 500, rate);
    chk("capacityAcc", 500, capAcc);
    chk("calAbort", a0, nA);
    cellMv <= 16'd3467;
    w(3);
    chk("calAbort", a0 + 1, nA);
    chk("calBusy", 0, cb);
    chk("rateMa", 700, rate);
    cellMv <= 16'd3500;
    senseOffsetUv <= 16'sd40;
    pulse(1);
    pulse(3);
    senseRawUv <= 16'sd1000;
    w(3);
    chk("senseCorrected", 16'sd960, corr);
    host_cmd_model_inst.send(1'b1, CMD_RAM_BASE, 16'($random(seed) & 8'hFF));
    host_cmd_model_inst.send(1'b1, CMD_CONTROL, SUB_RESET);
    w(2);
    pulse(2);
    host_cmd_model_inst.send(1'b1, CMD_CONTROL, SUB_RESET);
    w(2);
    host_cmd_model_inst.send(1'b1, CMD_CONTROL, SUB_RESET_DATA);
    rd(CMD_CONTROL, 16'h0101);
    w(4);
    conclude();
  end
endmodule
